// [hdl/supply_integrity_monitor.sv]
/*
 Supply integrity monitor: undervoltage reset, supply warning flag and
 interrupt, PLL lock flag and reset-source flags, reached over Avalon-MM.
 Assumes comparator and PLL inputs are asynchronous and the CPU supplies
 its interrupt mask, halt/wait state and vector-entry acknowledge.
*/
// What this block does
// - Hold chip reset while supply below hysteresis threshold
// - Drive reset pin low during undervoltage reset
// - Option selects three thresholds and enables detector
// - Undervoltage reset clears watchdog reset-source flag
// - Warning flag bit 1, real-time, read-only
// - Warning flag changes only by hardware
// - Warning detector only with detector enabled
// - Interrupt on warning crossing either direction
// - Serviced only if enabled and unmasked
// - Interrupt enable is bit 0, software read/write
// - Pending cleared on service routine entry
// - Wait mode unchanged; warning wakes from wait
// - Halt freezes register; no wake from halt
// - Lock flag bit 3, cleared only by power-on
// - Undervoltage flag bit 2, set hardware, software clears
// - Other resets keep undervoltage flag unchanged
// - Register resets to zero except undervoltage flag
// - Illegal opcode or prebyte also resets chip
`timescale 1ns/10ps
module supply_integrity_monitor (
	// Clock and power-on reset
	input  wire logic                                    clock,
	input  wire logic                                    rst_n,
	// Avalon-MM slave
	input  wire logic [supply_integrity_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                                    avs_read,
	input  wire logic                                    avs_write,
	input  wire logic [31:0]                             avs_writedata,
	input  wire logic [3:0]                              avs_byteenable,
	output logic      [31:0]                             avs_readdata,
	output logic                                         avs_waitrequest,
	output logic      [1:0]                              avs_response,
	// Option setting
	input  wire logic                                    opt_detector_enable,
	input  wire logic [1:0]                              opt_threshold_level,
	// Analog comparators, one per level, with hysteresis inside
	input  wire logic [2:0]                              uv_below_threshold,
	input  wire logic [2:0]                              warn_below_threshold,
	input  wire logic                                    pll_locked_async,
	// Other reset sources
	input  wire logic                                    watchdog_reset_req,
	input  wire logic                                    external_reset_req,
	input  wire logic                                    illegal_opcode,
	input  wire logic                                    illegal_prebyte,
	// CPU side
	input  wire logic                                    cpu_irq_mask,
	input  wire logic                                    cpu_halt_mode,
	input  wire logic                                    cpu_wait_mode,
	input  wire logic                                    cpu_irq_ack,
	output logic                                         warn_irq,
	output logic                                         wake_from_wait,
	output logic                                         chip_reset,
	// Reset pin, open drain
	output logic                                         reset_pin_out,
	output logic                                         reset_pin_oe
);
	localparam int NS = supply_integrity_pkg::SYNC_STAGES;

	logic [NS-1:0] uv_sync_ff;
	logic [NS-1:0] warn_sync_ff;
	logic [NS-1:0] lock_sync_ff;
	logic [2:0]    uv_raw;
	logic [2:0]    warn_raw;
	logic          uv_sel;
	logic          warn_sel;
	logic          uv_now;
	logic          warn_now;
	logic          lock_now;
	logic          warn_flag_ff;
	logic          warn_prev_ff;
	logic          irq_en_ff;
	logic          uv_rsf_ff;
	logic          wdg_rsf_ff;
	logic          lock_ff;
	logic          pending_ff;
	logic          soft_reset_ff;
	logic          uv_reset;
	logic          warn_edge;
	logic          wr_sicr;
	logic          wr_reason;
	logic          access;
	logic          hit;
	logic          resp_ff;
	logic [31:0]   rdata_ff;
	logic          done_ff;

	// Pick the comparator of the option-selected level
	function automatic logic level_pick(input logic [2:0] cmp, input logic [1:0] lvl);
		logic r;
		r = 1'b0;
		if (lvl == supply_integrity_pkg::LVL_LOW) begin
			r = cmp[0];
		end else if (lvl == supply_integrity_pkg::LVL_MED) begin
			r = cmp[1];
		end else begin
			r = cmp[2];
		end
		return r;
	endfunction

	// Comparators are free-running; pick before syncing so only one stage set per signal
	assign uv_sel   = level_pick(uv_below_threshold, opt_threshold_level);
	assign warn_sel = level_pick(warn_below_threshold, opt_threshold_level);
	assign uv_raw   = uv_below_threshold;
	assign warn_raw = warn_below_threshold;

	always_ff @(posedge clock) begin
		uv_sync_ff   <= {uv_sync_ff[NS-2:0], uv_sel};
		warn_sync_ff <= {warn_sync_ff[NS-2:0], warn_sel};
		lock_sync_ff <= {lock_sync_ff[NS-2:0], pll_locked_async};
	end

	assign uv_now   = opt_detector_enable & uv_sync_ff[NS-1];
	assign warn_now = opt_detector_enable & warn_sync_ff[NS-1];
	assign lock_now = lock_sync_ff[NS-1];
	assign uv_reset = uv_now;

	// Static reset for as long as the supply stays low
	always_comb begin
		chip_reset    = uv_reset | soft_reset_ff | watchdog_reset_req;
		reset_pin_out = 1'b0;
		reset_pin_oe  = uv_reset | watchdog_reset_req;
	end

	// Illegal code detection becomes a one-cycle-registered reset request
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			soft_reset_ff <= 1'b0;
		end else begin
			soft_reset_ff <= illegal_opcode | illegal_prebyte;
		end
	end

	// Live warning flag, frozen in halt
	always_ff @(posedge clock) begin
		if (!rst_n || uv_reset) begin
			warn_flag_ff <= 1'b0;
			warn_prev_ff <= 1'b0;
		end else if (!cpu_halt_mode) begin
			warn_flag_ff <= warn_now;
			warn_prev_ff <= warn_flag_ff;
		end
	end

	// Either crossing raises the request
	assign warn_edge = (warn_flag_ff != warn_prev_ff) & ~cpu_halt_mode;

	// Interrupt enable
	always_ff @(posedge clock) begin
		if (!rst_n || uv_reset) begin
			irq_en_ff <= 1'b0;
		end else if (wr_sicr && avs_byteenable[0] && !cpu_halt_mode) begin
			irq_en_ff <= avs_writedata[supply_integrity_pkg::IRQ_EN_BIT];
		end
	end

	// Pending request: set wins over service ack and enable clear
	always_ff @(posedge clock) begin
		if (!rst_n || uv_reset) begin
			pending_ff <= 1'b0;
		end else if (warn_edge && irq_en_ff) begin
			pending_ff <= 1'b1;
		end else if (cpu_irq_ack || !irq_en_ff) begin
			pending_ff <= 1'b0;
		end
	end

	assign warn_irq       = pending_ff & irq_en_ff & ~cpu_irq_mask;
	assign wake_from_wait = warn_irq & cpu_wait_mode & ~cpu_halt_mode;

	// Lock flag survives every reset except power-on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lock_ff <= 1'b0;
		end else if (lock_now && !cpu_halt_mode) begin
			lock_ff <= 1'b1;
		end
	end

	// Reset-source flags: uv_rsf_ff is not cleared by rst_n so the cause outlives resets; wdg_rsf_ff is cleared by rst_n
	always_ff @(posedge clock) begin
		if (uv_reset) begin
			uv_rsf_ff <= 1'b1;
		end else if (wr_sicr && avs_byteenable[0] && !cpu_halt_mode &&
			!avs_writedata[supply_integrity_pkg::UV_RSF_BIT]) begin
			uv_rsf_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (uv_reset) begin
			wdg_rsf_ff <= 1'b0;
		end else if (!rst_n) begin
			wdg_rsf_ff <= 1'b0;
		end else if (watchdog_reset_req) begin
			wdg_rsf_ff <= 1'b1;
		end else if (wr_reason && avs_byteenable[0] &&
			!avs_writedata[supply_integrity_pkg::WDG_RSF_BIT]) begin
			wdg_rsf_ff <= 1'b0;
		end
	end

	// Avalon slave: one wait cycle, answer on the second edge
	assign access  = (avs_read | avs_write) & ~done_ff;
	assign hit     = (avs_address == supply_integrity_pkg::SICR_ADDR) ||
	                 (avs_address == supply_integrity_pkg::REASON_ADDR) ||
	                 (avs_address == supply_integrity_pkg::MODE_ADDR);
	assign wr_sicr   = avs_write & done_ff & (avs_address == supply_integrity_pkg::SICR_ADDR);
	assign wr_reason = avs_write & done_ff & (avs_address == supply_integrity_pkg::REASON_ADDR);
	assign avs_waitrequest = (avs_read | avs_write) & ~done_ff;
	assign avs_readdata    = rdata_ff;
	assign avs_response    = resp_ff ? 2'b10 : 2'b00;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_ff  <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			resp_ff  <= 1'b0;
		end else begin
			done_ff <= access;
			// Response stands until the next answer, like the read data
			if (access) begin
				resp_ff <= ~hit;
			end
			if (access && avs_read) begin
				rdata_ff <= 32'h0000_0000;
				unique case (avs_address)
					supply_integrity_pkg::SICR_ADDR: begin
						rdata_ff[supply_integrity_pkg::IRQ_EN_BIT] <= irq_en_ff;
						rdata_ff[supply_integrity_pkg::WARN_BIT]   <= warn_flag_ff;
						rdata_ff[supply_integrity_pkg::UV_RSF_BIT] <= uv_rsf_ff;
						rdata_ff[supply_integrity_pkg::LOCK_BIT]   <= lock_ff;
					end
					supply_integrity_pkg::REASON_ADDR: begin
						rdata_ff[supply_integrity_pkg::WDG_RSF_BIT] <= wdg_rsf_ff;
					end
					supply_integrity_pkg::MODE_ADDR: begin
						rdata_ff[2:0] <= {opt_threshold_level, opt_detector_enable};
					end
					default: begin
						rdata_ff <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Keep per-level comparator buses, external_reset_req and unused bus bits referenced
	logic unused_ok;
	assign unused_ok = ^{uv_raw, warn_raw, external_reset_req, avs_writedata[31:8],
	                     avs_byteenable[3:1]};
endmodule

// [include/supply_integrity_pkg.sv]
/*
 Constants for the supply integrity monitor: register map, field positions,
 reset values and synchroniser depth. Assumes a single 200 MHz clock domain.
*/
package supply_integrity_pkg;
	// Register index as printed; byte address is four times it
	localparam logic [7:0]  SICR_INDEX      = 8'h3a;
	localparam logic [9:0]  SICR_ADDR       = 10'h0e8;
	localparam logic [9:0]  REASON_ADDR     = 10'h0ec;
	localparam logic [9:0]  MODE_ADDR       = 10'h0f0;
	localparam int          ADDR_W          = 10;
	// Field positions of supply_integrity_ctrl_status
	localparam int          IRQ_EN_BIT      = 0;
	localparam int          WARN_BIT        = 1;
	localparam int          UV_RSF_BIT      = 2;
	localparam int          LOCK_BIT        = 3;
	// Field positions of the reset reason register
	localparam int          WDG_RSF_BIT     = 0;
	// Reset value, threshold level codes and synchroniser depth
	localparam logic [7:0]  SICR_RESET      = 8'h00;
	localparam logic [1:0]  LVL_LOW         = 2'h0;
	localparam logic [1:0]  LVL_MED         = 2'h1;
	localparam logic [1:0]  LVL_HIGH        = 2'h2;
	localparam int          SYNC_STAGES     = 2;
	// Reset source encoding seen by the reset controller
	typedef enum logic [1:0] {
		RST_NONE     = 2'b00,
		RST_UNDERVOL = 2'b01,
		RST_WATCHDOG = 2'b10,
		RST_OTHER    = 2'b11
	} reset_cause_t;
endpackage

// [testbench/supply_integrity_properties.sv]
/*
 Port checker for the supply integrity monitor.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module supply_integrity_properties (
	// Clock, reset and bus
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Supply, reset and CPU side
	input wire logic        opt_detector_enable,
	input wire logic [2:0]  uv_below_threshold,
	input wire logic        watchdog_reset_req,
	input wire logic        illegal_opcode,
	input wire logic        cpu_irq_mask,
	input wire logic        cpu_halt_mode,
	input wire logic        cpu_wait_mode,
	input wire logic        warn_irq,
	input wire logic        wake_from_wait,
	input wire logic        chip_reset,
	input wire logic        reset_pin_out,
	input wire logic        reset_pin_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest) else $error("request not answered after one wait");
	rsvd_zero_a: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:4] == 28'h0) else $error("reserved read bits set");
	pin_low_a: assert property (reset_pin_oe |-> !reset_pin_out)
		else $error("reset pin driven high");
	wdg_pin_a: assert property (watchdog_reset_req |-> chip_reset && reset_pin_oe)
		else $error("watchdog reset not on pin");
	// Five samples cover the two sync stages, which need three, with two to spare
	uv_reset_a: assert property ((opt_detector_enable && uv_below_threshold == 3'h7) [*5]
		|-> chip_reset && reset_pin_oe) else $error("undervoltage reset missing");
	illegal_a: assert property (illegal_opcode |=> chip_reset)
		else $error("illegal code reset missing");
	irq_mask_a: assert property (warn_irq |-> !cpu_irq_mask)
		else $error("interrupt while masked");
	wake_wait_a: assert property (wake_from_wait ==
		(warn_irq && cpu_wait_mode && !cpu_halt_mode)) else $error("wake mismatch");
	cover property (warn_irq);
	cover property (wake_from_wait);
	cover property ($fell(avs_waitrequest));
endmodule
bind supply_integrity_monitor supply_integrity_properties chk (.clock, .rst_n, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .opt_detector_enable, .uv_below_threshold,
	.watchdog_reset_req, .illegal_opcode, .cpu_irq_mask, .cpu_halt_mode, .cpu_wait_mode,
	.warn_irq, .wake_from_wait, .chip_reset, .reset_pin_out, .reset_pin_oe);

// [testbench/supply_partner_model.sv]
/*
 Comparators and vector-entry acknowledge facing the monitor.
 Assumes supply in tenths of a volt; no hysteresis is modelled.
*/
`timescale 1ns/10ps
module supply_partner_model (
	// Stimulus
	input wire logic       clock,
	input wire logic [7:0] supply_dv,
	input wire logic       ack_on,
	input wire logic       warn_irq,
	// To the monitor
	output logic [2:0]     uv_below_threshold,
	output logic [2:0]     warn_below_threshold,
	output logic           cpu_irq_ack
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			uv_below_threshold[i] = supply_dv < 8'h1c + 8'(4 * i);
			warn_below_threshold[i] = supply_dv < 8'h20 + 8'(4 * i);
		end
	end
	// One-cycle entry pulse, like the core taking the vector
	always_ff @(posedge clock) begin
		cpu_irq_ack <= ack_on && warn_irq && !cpu_irq_ack;
	end
endmodule

// [testbench/tb.sv]
/*
 Self-checking bench for the supply integrity monitor.
 Assumes the partner model drives comparators and acknowledges.
*/
`timescale 1ns/10ps
module tb;
	localparam logic [9:0] ST = supply_integrity_pkg::SICR_ADDR;
	localparam logic [9:0] RS = supply_integrity_pkg::REASON_ADDR;
	logic        clock, rst_n, avs_read, avs_write, opt_detector_enable, pll_locked_async;
	logic        watchdog_reset_req, external_reset_req, illegal_opcode, illegal_prebyte;
	logic        cpu_irq_mask, cpu_halt_mode, cpu_wait_mode, cpu_irq_ack, ack_on;
	logic        avs_waitrequest, warn_irq, wake_from_wait, chip_reset, reset_pin_out;
	logic        reset_pin_oe;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0]  avs_response, opt_threshold_level;
	logic [2:0]  uv_below_threshold, warn_below_threshold;
	logic [7:0]  supply_dv;
	int          errors, tests_run;
	supply_partner_model model (.clock, .supply_dv, .ack_on, .warn_irq, .uv_below_threshold,
		.warn_below_threshold, .cpu_irq_ack);
	supply_integrity_monitor uut (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .avs_response,
		.opt_detector_enable, .opt_threshold_level, .uv_below_threshold, .warn_below_threshold,
		.pll_locked_async, .watchdog_reset_req, .external_reset_req, .illegal_opcode,
		.illegal_prebyte, .cpu_irq_mask, .cpu_halt_mode, .cpu_wait_mode, .cpu_irq_ack,
		.warn_irq, .wake_from_wait, .chip_reset, .reset_pin_out, .reset_pin_oe);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (!avs_waitrequest)
				break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20) begin
			errors++;
			final_report();
		end
	endtask
	// Bit 2 may be unknown before the first undervoltage or clearing write, so it is masked until then
	task automatic rdc(input string n, input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, {24'h0, e}, rd & {24'hffffff, m});
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	initial begin
		{avs_read, avs_write, ack_on, pll_locked_async, watchdog_reset_req} = 5'h0;
		{external_reset_req, illegal_opcode, illegal_prebyte} = 3'h0;
		{cpu_irq_mask, cpu_halt_mode, cpu_wait_mode} = 3'h0;
		avs_address = 10'h0;
		avs_writedata = 32'h0;
		opt_detector_enable = 1'b1;
		opt_threshold_level = supply_integrity_pkg::LVL_MED;
		supply_dv = 8'h40;
		rst_n = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rdc("reset", ST, 8'hfb, 8'h00);
		bus(1'b0, 10'h3fc, 32'h0);
		chk("unmapped resp", 32'h2, {30'h0, avs_response});
		chk("unmapped data", 32'h0, rd);
		bus(1'b1, ST, 32'hff);
		rdc("write ones", ST, 8'hfb, 8'h01);
		bus(1'b1, ST, 32'h0);
		rdc("clear", ST, 8'hff, 8'h00);
		@(posedge clock);
		pll_locked_async <= 1'b1;
		step(5);
		rdc("lock", ST, 8'hff, 8'h08);
		$display("register test done");
		bus(1'b1, ST, 32'h1);
		@(posedge clock);
		supply_dv <= 8'h22;
		step(5);
		rdc("warn flag", ST, 8'hff, 8'h0b);
		chk("irq falling", 32'h1, {31'h0, warn_irq});
		@(posedge clock);
		cpu_irq_mask <= 1'b1;
		step(1);
		chk("irq masked", 32'h0, {31'h0, warn_irq});
		@(posedge clock);
		cpu_irq_mask <= 1'b0;
		cpu_wait_mode <= 1'b1;
		step(1);
		chk("wake wait", 32'h1, {31'h0, wake_from_wait});
		@(posedge clock);
		cpu_halt_mode <= 1'b1;
		step(1);
		chk("wake halt", 32'h0, {31'h0, wake_from_wait});
		bus(1'b1, ST, 32'h0);
		rdc("frozen", ST, 8'hff, 8'h0b);
		@(posedge clock);
		{cpu_halt_mode, cpu_wait_mode, ack_on} <= 3'h1;
		step(3);
		chk("irq acked", 32'h0, {31'h0, warn_irq});
		@(posedge clock);
		ack_on <= 1'b0;
		supply_dv <= 8'h40;
		step(5);
		chk("irq rising", 32'h1, {31'h0, warn_irq});
		rdc("warn gone", ST, 8'hff, 8'h09);
		bus(1'b1, ST, 32'h0);
		step(1);
		chk("irq disabled", 32'h0, {31'h0, warn_irq});
		bus(1'b1, ST, 32'h1);
		@(posedge clock);
		opt_detector_enable <= 1'b0;
		supply_dv <= 8'h22;
		step(5);
		chk("irq off", 32'h0, {31'h0, warn_irq});
		rdc("warn off", ST, 8'h02, 8'h00);
		@(posedge clock);
		opt_detector_enable <= 1'b1;
		supply_dv <= 8'h40;
		@(posedge clock);
		watchdog_reset_req <= 1'b1;
		@(posedge clock);
		watchdog_reset_req <= 1'b0;
		step(5);
		rdc("wdg flag", RS, 8'h01, 8'h01);
		for (int l = 0; l < 3; l++) begin
			@(posedge clock);
			opt_threshold_level <= 2'(l);
			supply_dv <= 8'h1c + 8'(4 * l);
			step(5);
			chk("uv above", 32'h0, {31'h0, chip_reset});
			@(posedge clock);
			supply_dv <= 8'h1b + 8'(4 * l);
			step(5);
			chk("uv below", 32'h3, {30'h0, chip_reset, reset_pin_oe});
		end
		@(posedge clock);
		supply_dv <= 8'h40;
		step(5);
		rdc("wdg cleared", RS, 8'h01, 8'h00);
		rdc("uv flag", ST, 8'hf7, 8'h04);
		@(posedge clock);
		external_reset_req <= 1'b1;
		@(posedge clock);
		external_reset_req <= 1'b0;
		step(3);
		rdc("uv kept", ST, 8'hf7, 8'h04);
		@(posedge clock);
		illegal_opcode <= 1'b1;
		@(posedge clock);
		{illegal_opcode, illegal_prebyte} <= 2'h1;
		#1;
		chk("opcode reset", 32'h1, {31'h0, chip_reset});
		@(posedge clock);
		illegal_prebyte <= 1'b0;
		#1;
		chk("prebyte reset", 32'h1, {31'h0, chip_reset});
		$display("supply test done");
		final_report();
	end
endmodule
